// *** rtl/cbsc_ctrl.sv ***
// state machine of the two-cell inductive balancer
`timescale 1ns/1ps
`include "cbsc_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// RQ1: after reset the controller starts in checking, not sleeping or balancing.
// RQ2: any fault forces sleep at once and stops all switching.
// RQ3: in checking, a kick comparator hit moves to balancing.
// RQ4: top cell higher selects down direction, top feeds bottom.
// RQ5: bottom cell higher selects up direction, bottom feeds top.
// RQ6: each balancing episode starts in constant-current phase.
// RQ7: near-zero difference enters dimming, current allowed to fall slowly.
// RQ8: near-zero current held for the finishing time ends balancing to sleep.
// RQ9: either cell below precondition limits current to ten percent.
// RQ10: cell over-voltage stops balancing, sleeps, wakes after sleep interval.
// RQ11: die over-temperature stops balancing, sleeps, wakes after sleep interval.
// RQ12: peak current comparator ends the active switching phase.
// RQ13: no unbalance within the checking time returns to sleep.
// RQ14: balancing allowed only with supply above lockout and below over-voltage.
// RQ15: sleep interval expiry with no fault re-enters checking.
module cbsc_ctrl #(
	parameter logic [31:0] CHECK_CYCLES = 32'(`CBSC_CHECK_CYCLES),
	parameter logic [31:0] SLEEP_CYCLES = 32'(`CBSC_SLEEP_CYCLES),
	parameter logic [31:0] DONE_CYCLES = 32'(`CBSC_DONE_CYCLES)
)
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// comparators
	input wire logic i_kick_detect,
	input wire logic i_top_higher,
	input wire logic i_diff_near_zero,
	input wire logic i_current_near_zero,
	input wire logic i_top_below_precond,
	input wire logic i_bot_below_precond,
	input wire logic i_peak_current_hit,
	// faults
	input wire logic i_cell_overvoltage,
	input wire logic i_over_temperature,
	input wire logic i_supply_uvlo,
	input wire logic i_supply_ovp,
	input wire logic i_other_fault,
	// status and power stage control
	output logic [1:0] o_state,
	output logic o_dir_up,
	output logic o_switch_enable,
	output logic o_phase_cc,
	output logic o_phase_dim,
	output logic o_precond_limit,
	output logic o_cycle_end
);
	////////////////////////////////////////////////////////////////////////////
	cbsc_pkg::cbsc_state_t state, next_state;
	cbsc_pkg::cbsc_phase_t phase, next_phase;
	logic [31:0] done_count;
	logic switching;
	logic dir_up;
	logic armed;
	cbsc_timer_if tif ();
	cbsc_timer u_timer
	(
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.tif(tif)
	);
	////////////////////////////////////////////////////////////////////////////
	// fault decode; supply window faults also block balancing
	wire supply_bad = i_supply_uvlo || i_supply_ovp; // RQ14
	wire any_fault = i_cell_overvoltage || i_over_temperature || supply_bad
		|| i_other_fault; // RQ2 RQ10 RQ11
	wire in_sleep = (state == cbsc_pkg::CBSC_SLEEP);
	wire in_check = (state == cbsc_pkg::CBSC_CHECK);
	wire in_bal = (state == cbsc_pkg::CBSC_BALANCE);
	wire start_bal = in_check && i_kick_detect && !any_fault; // RQ3 RQ14
	wire check_over = in_check && tif.expired && !start_bal; // RQ13
	wire wake = in_sleep && tif.expired && !any_fault; // RQ15
	wire done_hit = in_bal && i_current_near_zero
		&& (done_count >= DONE_CYCLES - `CBSC_TIMER_ONE); // RQ8
	// fault still present at expiry: sleep another interval instead of stalling
	wire resleep = in_sleep && tif.expired && any_fault; // RQ10 RQ11
	wire precond = i_top_below_precond || i_bot_below_precond; // RQ9
	// timer is reloaded on every sleep or check entry, not on balance entry; empty after reset, so arm it once
	wire enter_sleep = !in_sleep && (any_fault || check_over || done_hit);
	wire sleep_load = enter_sleep || resleep;
	assign tif.load = sleep_load || wake || !armed; // RQ13
	assign tif.count = sleep_load ? SLEEP_CYCLES : CHECK_CYCLES;
	assign tif.run = in_sleep || in_check;
	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_state = state;
		next_phase = phase;
		unique case (state)
			cbsc_pkg::CBSC_SLEEP:
				if (wake)
					next_state = cbsc_pkg::CBSC_CHECK; // RQ15
			cbsc_pkg::CBSC_CHECK:
				if (any_fault || check_over)
					next_state = cbsc_pkg::CBSC_SLEEP; // RQ2 RQ13
				else if (start_bal)
				begin
					next_state = cbsc_pkg::CBSC_BALANCE; // RQ3
					next_phase = cbsc_pkg::CBSC_PH_CC; // RQ6
				end
			cbsc_pkg::CBSC_BALANCE:
				if (any_fault || done_hit)
					next_state = cbsc_pkg::CBSC_SLEEP; // RQ2 RQ8
				else if (i_diff_near_zero)
					next_phase = cbsc_pkg::CBSC_PH_DIM; // RQ7
			default:
				next_state = cbsc_pkg::CBSC_SLEEP;
		endcase
		if (next_state != cbsc_pkg::CBSC_BALANCE)
			next_phase = cbsc_pkg::CBSC_PH_IDLE;
	end
	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state <= cbsc_pkg::CBSC_CHECK; // RQ1
			phase <= cbsc_pkg::CBSC_PH_IDLE;
		end
		else
		begin
			state <= next_state;
			phase <= next_phase;
		end
	end
	// first edge after reset opens the check window
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
			armed <= 1'b0;
		else
			armed <= 1'b1; // RQ1 RQ13
	end
	// direction latched at balance entry
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
			dir_up <= 1'b0;
		else if (start_bal)
			dir_up <= !i_top_higher; // RQ4 RQ5
	end
	// near-zero current persistence counter, restarts on any break
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
			done_count <= `CBSC_TIMER_ZERO;
		else if (in_bal && i_current_near_zero && !done_hit)
			done_count <= done_count + `CBSC_TIMER_ONE; // RQ8
		else
			done_count <= `CBSC_TIMER_ZERO;
	end
	// peak comparator cuts switching only while asserted
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
			switching <= 1'b0;
		else
			switching <= (next_state == cbsc_pkg::CBSC_BALANCE) && !any_fault
				&& !i_peak_current_hit; // RQ2 RQ12
	end
	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_state <= cbsc_pkg::CBSC_CHECK; // RQ1
			o_dir_up <= 1'b0;
			o_phase_cc <= 1'b0;
			o_phase_dim <= 1'b0;
			o_precond_limit <= 1'b0;
			o_cycle_end <= 1'b0;
		end
		else
		begin
			o_state <= next_state;
			o_dir_up <= start_bal ? !i_top_higher : dir_up;
			o_phase_cc <= (next_phase == cbsc_pkg::CBSC_PH_CC);
			o_phase_dim <= (next_phase == cbsc_pkg::CBSC_PH_DIM);
			o_precond_limit <= precond && (next_state == cbsc_pkg::CBSC_BALANCE); // RQ9
			o_cycle_end <= done_hit && !any_fault;
		end
	end
	assign o_switch_enable = switching;
	////////////////////////////////////////////////////////////////////////////
	property p_fault_sleep;
		@(posedge i_clock) disable iff (!i_nrst)
		any_fault |=> (state == cbsc_pkg::CBSC_SLEEP) && !o_switch_enable;
	endproperty
	a_fault_sleep: assert property (p_fault_sleep) else $error("fault did not force sleep"); // RQ2
	property p_kick;
		@(posedge i_clock) disable iff (!i_nrst)
		start_bal |=> in_bal && o_phase_cc;
	endproperty
	a_kick: assert property (p_kick) else $error("kick did not start balancing"); // RQ3
	property p_dir;
		@(posedge i_clock) disable iff (!i_nrst)
		start_bal |=> (o_dir_up == !$past(i_top_higher));
	endproperty
	a_dir: assert property (p_dir) else $error("wrong direction"); // RQ4
	property p_cc_first;
		@(posedge i_clock) disable iff (!i_nrst)
		$rose(in_bal) |-> (phase == cbsc_pkg::CBSC_PH_CC);
	endproperty
	a_cc_first: assert property (p_cc_first) else $error("episode not in cc"); // RQ6
	property p_dim;
		@(posedge i_clock) disable iff (!i_nrst)
		(in_bal && i_diff_near_zero && !any_fault && !done_hit) |=> o_phase_dim;
	endproperty
	a_dim: assert property (p_dim) else $error("dimming not entered"); // RQ7
	property p_done;
		@(posedge i_clock) disable iff (!i_nrst)
		(done_hit && !any_fault) |=> in_sleep ##0 o_cycle_end;
	endproperty
	a_done: assert property (p_done) else $error("done did not sleep"); // RQ8
	property p_precond;
		@(posedge i_clock) disable iff (!i_nrst)
		(precond && in_bal && !any_fault && !done_hit) |=> o_precond_limit;
	endproperty
	a_precond: assert property (p_precond) else $error("precond limit missing"); // RQ9
	property p_peak;
		@(posedge i_clock) disable iff (!i_nrst)
		i_peak_current_hit |=> !o_switch_enable;
	endproperty
	a_peak: assert property (p_peak) else $error("peak did not stop switching"); // RQ12
	property p_check_out;
		@(posedge i_clock) disable iff (!i_nrst)
		check_over && !any_fault |=> in_sleep;
	endproperty
	a_check_out: assert property (p_check_out) else $error("check timeout ignored"); // RQ13
	property p_wake;
		@(posedge i_clock) disable iff (!i_nrst)
		wake |=> in_check;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake to check"); // RQ15
endmodule : cbsc_ctrl

// *** rtl/cbsc_defs.svh ***
// timing and threshold constants for the cell balance state controller
`ifndef CBSC_DEFS_SVH
`define CBSC_DEFS_SVH
`define CBSC_CLK_PERIOD_PS 4000
`define CBSC_CHECK_TIME_NS 7680000
`define CBSC_ALLOW_TIME_NS 3850000
`define CBSC_SLEEP_TIME_MS 2000
`define CBSC_DONE_TIME_MS 62
`define CBSC_KICK_MV 100
`define CBSC_DIE_LIMIT_C 160
`define CBSC_PEAK_LIMIT_MA 5500
`define CBSC_PRECOND_PERCENT 10
`define CBSC_CHECK_CYCLES ((`CBSC_CHECK_TIME_NS * 64'd1000) / `CBSC_CLK_PERIOD_PS)
`define CBSC_SLEEP_CYCLES ((`CBSC_SLEEP_TIME_MS * 64'd1000000000) / `CBSC_CLK_PERIOD_PS)
`define CBSC_DONE_CYCLES ((`CBSC_DONE_TIME_MS * 64'd1000000000) / `CBSC_CLK_PERIOD_PS)
`define CBSC_TIMER_W 32
`define CBSC_TIMER_ZERO 32'h0000_0000
`define CBSC_TIMER_ONE 32'h0000_0001
`endif

// *** rtl/cbsc_pkg.sv ***
// types for the cell balance state controller
package cbsc_pkg;
	typedef enum logic [1:0]
	{
		CBSC_SLEEP = 2'h0,
		CBSC_CHECK = 2'h1,
		CBSC_BALANCE = 2'h3
	} cbsc_state_t;
	typedef enum logic [1:0]
	{
		CBSC_PH_IDLE = 2'h0,
		CBSC_PH_CC = 2'h1,
		CBSC_PH_DIM = 2'h3
	} cbsc_phase_t;
endpackage : cbsc_pkg

// *** rtl/cbsc_timer_if.sv ***
// load and expiry signals between controller and its interval timer
`timescale 1ns/1ps
interface cbsc_timer_if;
	logic load;
	logic run;
	logic [31:0] count;
	logic expired;
	modport ctrl (output load, output run, output count, input expired);
	modport timer (input load, input run, input count, output expired);
endinterface : cbsc_timer_if

// *** rtl/cbsc_timer.sv ***
// reloadable down counter; expired is a one-cycle pulse at reaching one
`timescale 1ns/1ps
`include "cbsc_defs.svh"
module cbsc_timer
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// control
	cbsc_timer_if.timer tif
);
	logic [31:0] remaining;
	wire running = tif.run && (remaining != `CBSC_TIMER_ZERO);
	wire at_end = running && (remaining == `CBSC_TIMER_ONE);
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
			remaining <= `CBSC_TIMER_ZERO;
		else if (tif.load)
			remaining <= tif.count;
		else if (running)
			remaining <= remaining - `CBSC_TIMER_ONE;
	end
	// not gated by load: the controller reloads on expiry, gating would loop
	assign tif.expired = at_end;
endmodule : cbsc_timer

// *** dv/cbsc_analog_model.sv ***
// behavioural comparators that sense the two cells for the controller
`timescale 1ns/1ps
module cbsc_analog_model #(
	parameter logic [15:0] KICK_MV = 16'h0064,
	parameter logic [15:0] NEAR_MV = 16'h000A,
	parameter logic [15:0] PRECOND_MV = 16'h0AF0,
	parameter logic [15:0] OVP_MV = 16'h1388
)
(
	// cell voltages in millivolts
	input wire logic [15:0] i_top_mv,
	input wire logic [15:0] i_bot_mv,
	// comparator results
	output logic o_kick,
	output logic o_top_higher,
	output logic o_diff_near_zero,
	output logic o_top_below_precond,
	output logic o_bot_below_precond,
	output logic o_cell_overvoltage
);
	wire [15:0] diff_mv;
	assign diff_mv = (i_top_mv > i_bot_mv) ? i_top_mv - i_bot_mv : i_bot_mv - i_top_mv;
	assign o_kick = diff_mv > KICK_MV;
	assign o_top_higher = i_top_mv > i_bot_mv;
	// ideal comparator, no hysteresis modelled
	assign o_diff_near_zero = diff_mv <= NEAR_MV;
	assign o_top_below_precond = i_top_mv < PRECOND_MV;
	assign o_bot_below_precond = i_bot_mv < PRECOND_MV;
	assign o_cell_overvoltage = (i_top_mv > OVP_MV) || (i_bot_mv > OVP_MV);
endmodule : cbsc_analog_model

// *** dv/tb_cell_balance_state_controller.sv ***
// self-checking bench for the cell balance state controller
`timescale 1ns/1ps
module tb_cell_balance_state_controller;
	typedef struct packed
	{
		logic [15:0] top;
		logic [15:0] bot;
		logic [3:0] flt;
		logic [1:0] st;
		logic up;
		logic pre;
	} cbsc_row_t;
	localparam int CHK = 40;
	localparam int SLP = 60;
	localparam int DN = 20;
	logic i_clock = 1'h0;
	logic i_nrst = 1'h0;
	logic [15:0] top_mv = 16'hFA0;
	logic [15:0] bot_mv = 16'hFA0;
	logic [3:0] flt = 4'h0;
	logic cur_nz = 1'h0;
	logic peak = 1'h0;
	logic kick, top_hi, diff_nz, top_pre, bot_pre, cell_ov;
	logic [1:0] st;
	logic up, sw, cc, dim, pre, done;
	int n_fail = 0;
	int tests_run = 0;
	int cycles = 0;
	int n;
	cbsc_row_t rows [9];
	cbsc_analog_model model_u (.i_top_mv(top_mv), .i_bot_mv(bot_mv), .o_kick(kick),
		.o_top_higher(top_hi), .o_diff_near_zero(diff_nz), .o_top_below_precond(top_pre),
		.o_bot_below_precond(bot_pre), .o_cell_overvoltage(cell_ov));
	cbsc_ctrl #(.CHECK_CYCLES(32'(CHK)), .SLEEP_CYCLES(32'(SLP)), .DONE_CYCLES(32'(DN))) dut_u (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_kick_detect(kick), .i_top_higher(top_hi),
		.i_diff_near_zero(diff_nz), .i_current_near_zero(cur_nz),
		.i_top_below_precond(top_pre), .i_bot_below_precond(bot_pre),
		.i_peak_current_hit(peak), .i_cell_overvoltage(cell_ov), .i_over_temperature(flt[3]),
		.i_supply_uvlo(flt[2]), .i_supply_ovp(flt[1]), .i_other_fault(flt[0]), .o_state(st),
		.o_dir_up(up), .o_switch_enable(sw), .o_phase_cc(cc), .o_phase_dim(dim),
		.o_precond_limit(pre), .o_cycle_end(done));
	initial
	begin
		forever #2 i_clock = ~i_clock;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int k);
		repeat (k) @(posedge i_clock);
		#1;
	endtask : tick
	task automatic rst(input int k);
		i_nrst = 1'h0;
		top_mv = 16'hFA0;
		bot_mv = 16'hFA0;
		flt = 4'h0;
		cur_nz = 1'h0;
		peak = 1'h0;
		tick(k);
		i_nrst = 1'h1;
	endtask : rst
	task automatic wait_st(input logic [1:0] s, input int lim);
		n = 0;
		while (st !== s && n < lim)
		begin
			tick(1);
			n++;
		end
	endtask : wait_st
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	// hang guard, well above the length of all tests
	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_fail++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rows = '{'{16'hFA0, 16'hED8, 4'h0, 2'h3, 1'h0, 1'h0}, '{16'hED8, 16'hFA0, 4'h0, 2'h3, 1'h1, 1'h0},
			'{16'hED8, 16'hEA6, 4'h0, 2'h1, 1'h0, 1'h0}, '{16'hFA0, 16'h9C4, 4'h0, 2'h3, 1'h0, 1'h1},
			'{16'h13EC, 16'hFA0, 4'h0, 2'h0, 1'h0, 1'h0}, '{16'hFA0, 16'hED8, 4'h8, 2'h0, 1'h0, 1'h0},
			'{16'hFA0, 16'hED8, 4'h4, 2'h0, 1'h0, 1'h0}, '{16'hFA0, 16'hED8, 4'h2, 2'h0, 1'h0, 1'h0},
			'{16'hFA0, 16'hED8, 4'h1, 2'h0, 1'h0, 1'h0}};
		i_nrst = 1'h0;
		tick(5);
		check(st, 2'(cbsc_pkg::CBSC_CHECK));
		check({sw, cc}, 2'h0);
		rst(1);
		$display("reset test done");
		foreach (rows[i])
		begin
			rst(2);
			top_mv = rows[i].top;
			bot_mv = rows[i].bot;
			flt = rows[i].flt;
			tick(1);
			check(st, rows[i].st);
			check({up, pre}, {rows[i].up, rows[i].pre});
			check({sw, cc}, {2{rows[i].st == 2'h3}});
		end
		$display("row tests done");
		rst(2);
		bot_mv = 16'hED8;
		tick(1);
		bot_mv = 16'hFA0;
		tick(1);
		check({dim, cc}, 2'h2);
		cur_nz = 1'h1;
		n = 0;
		while (done !== 1'h1 && n < 40)
		begin
			tick(1);
			n++;
		end
		check(n >= DN - 2 && n <= DN + 2, 1'h1);
		check({st, sw}, 3'h0);
		tick(1);
		check(done, 1'h0);
		wait_st(2'h1, 100);
		check(n >= SLP - 3 && n <= SLP + 3, 1'h1);
		cur_nz = 1'h0;
		wait_st(2'h0, 100);
		check(n >= CHK - 3 && n <= CHK + 3, 1'h1);
		$display("finish and timeout test done");
		rst(2);
		top_mv = 16'hED8;
		tick(1);
		peak = 1'h1;
		tick(1);
		check({st, sw}, 3'h6);
		peak = 1'h0;
		tick(1);
		check(sw, 1'h1);
		flt = 4'h8;
		tick(1);
		check({st, sw, cc}, 4'h0);
		tick(SLP + 5);
		check(st, 2'h0);
		flt = 4'h0;
		wait_st(2'h1, 100);
		check(n > 0 && n <= SLP, 1'h1);
		$display("peak and fault test done");
		complete_run();
	end
endmodule : tb_cell_balance_state_controller
